/* inc/irf_pkg.sv */
package irf_pkg;
  // ************************************************************
  // register map, byte addresses on the avalon word bus
  // ************************************************************
  localparam logic [3:0] IRF_OFS_TSP = 4'h0;
  localparam logic [3:0] IRF_OFS_PER = 4'h4;
  localparam logic [3:0] IRF_OFS_WKP = 4'h8;
  localparam logic [3:0] IRF_OFS_CTL = 4'hc;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int IRF_TSP_TA = 7;
  localparam int IRF_TSP_S1 = 6;
  localparam int IRF_TSP_FIX = 5;
  localparam int IRF_PER_DT = 7;
  localparam int IRF_PER_AD = 6;
  localparam int IRF_PER_RSV = 5;
  localparam int IRF_PER_TG = 4;
  localparam int IRF_PER_TFH = 3;
  localparam int IRF_PER_TFL = 2;
  localparam int IRF_PER_TC = 1;
  localparam int IRF_PER_EC = 0;
  // control register: [4:0] pin edge select, [15:8] wakeup edge select
  localparam int IRF_CTL_PES_LSB = 0;
  localparam int IRF_CTL_WES_LSB = 8;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] IRF_RST_FLAGS = 8'h00;
  localparam logic [4:0] IRF_RST_PES = 5'h00;
  localparam logic [7:0] IRF_RST_WES = 8'h00;
  localparam logic [7:0] IRF_CNT_MAX = 8'hff;
  localparam logic [7:0] IRF_CNT_ZERO = 8'h00;

  // peripheral event inputs, one-cycle or level as named
  typedef struct packed {
    logic [7:0] interval_count;
    logic serial_one_done;
    logic sleep_exec;
    logic direct_transfer_on;
    logic converter_start_flag;
    logic timer_g_capture_edge;
    logic timer_g_overflow;
    logic overflow_irq_enable;
    logic timer_f_16bit_mode;
    logic [7:0] timer_f_count_high;
    logic [7:0] timer_f_count_low;
    logic [7:0] timer_f_compare_high;
    logic [7:0] timer_f_compare_low;
    logic [7:0] timer_c_count;
    logic event_16bit_mode;
    logic event_count_high_ovf;
    logic event_count_low_ovf;
  } irf_periph_t;
endpackage : irf_pkg

/* logic/irf_edge_det.sv */
`timescale 1ns/1ps
`default_nettype none
// edge detector per pin: sel 0 falling, 1 rising, gated by enable
module irf_edge_det #(
  parameter int N = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [N-1:0] pin,
  input wire logic [N-1:0] pin_en,
  input wire logic [N-1:0] sel,
  output logic [N-1:0] hit
);
  logic [N-1:0] prev;
  logic [N-1:0] next_prev;

  always_comb begin
    next_prev = pin;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev <= '1;
    end else begin
      prev <= next_prev;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      assign hit[i] = pin_en[i] & (sel[i] ? (pin[i] & ~prev[i])
                                          : (~pin[i] & prev[i]));
    end
  endgenerate
endmodule : irf_edge_det
`default_nettype wire

/* logic/irf_top.sv */
// Function
// - software writes may only clear flags, except second register bit 5, which takes the written value
// - acceptance never clears a flag
// - interval counter wrap sets its flag
// - serial one transfer done sets flag
// - first register bit 5 reads one
// - enabled external pin edge sets flag
// - second register bit 5 plain storage
// - sleep with direct transfer on sets
// - converter busy falling sets flag
// - capture edge or enabled overflow sets
// - timer f high match sets in 8-bit mode, full 16-bit match in 16-bit mode
// - timer f low match, 8-bit mode
// - timer c wrap either way sets
// - event counter overflow per mode sets
// - enabled wakeup pin edge sets flag
// - wakeup flags clear only by zero
// - pin edge select, zero means falling
// - wakeup edge select, resets to falling
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module irf_top
  import irf_pkg::*;
#(
  parameter int PINS = 5,
  parameter int WAKES = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire irf_periph_t periph,
  input wire logic [PINS-1:0] external_request_pin,
  input wire logic [PINS-1:0] external_pin_enable,
  input wire logic [WAKES-1:0] wakeup_pin,
  input wire logic [WAKES-1:0] wakeup_pin_enable,
  output logic [7:0] timer_serial_pin_flags,
  output logic [7:0] peripheral_flags,
  output logic [7:0] wakeup_flags
);
  // ************************************************************
  // state
  // ************************************************************
  logic [7:0] timer_serial_pin_request_flags;
  logic [7:0] peripheral_request_flags;
  logic [7:0] wakeup_request_flags;
  logic [PINS-1:0] pin_edge_select;
  logic [WAKES-1:0] wakeup_edge_select;
  logic [7:0] prev_interval;
  logic [7:0] prev_timer_c;
  logic prev_converter_start_flag;
  logic acked;
  logic [31:0] rdata;

  logic [7:0] next_tsp;
  logic [7:0] next_per;
  logic [7:0] next_wkp;
  logic [PINS-1:0] next_pes;
  logic [WAKES-1:0] next_wes;
  logic [7:0] next_prev_interval;
  logic [7:0] next_prev_timer_c;
  logic next_prev_converter_start_flag;
  logic next_acked;
  logic [31:0] next_rdata;

  logic [PINS-1:0] pin_hit;
  logic [WAKES-1:0] wake_hit;
  logic [7:0] set_tsp;
  logic [7:0] set_per;
  logic wr_go;
  logic rd_go;
  logic [7:0] wmask;

  // ************************************************************
  // pin edge detection
  // ************************************************************
  irf_edge_det #(.N(PINS)) u_pin_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(external_request_pin),
    .pin_en(external_pin_enable),
    .sel(pin_edge_select),
    .hit(pin_hit)
  );

  irf_edge_det #(.N(WAKES)) u_wake_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(wakeup_pin),
    .pin_en(wakeup_pin_enable),
    .sel(wakeup_edge_select),
    .hit(wake_hit)
  );

  // ************************************************************
  // set conditions
  // ************************************************************
  always_comb begin
    set_tsp = 8'h00;
    set_per = 8'h00;
    set_tsp[IRF_TSP_TA] = (prev_interval == IRF_CNT_MAX) &&
                          (periph.interval_count == IRF_CNT_ZERO);
    set_tsp[IRF_TSP_S1] = periph.serial_one_done;
    set_tsp[PINS-1:0] = pin_hit;
    set_per[IRF_PER_DT] = periph.sleep_exec &
                          periph.direct_transfer_on;
    set_per[IRF_PER_AD] = prev_converter_start_flag & ~periph.converter_start_flag;
    set_per[IRF_PER_TG] = periph.timer_g_capture_edge |
                          (periph.timer_g_overflow &
                           periph.overflow_irq_enable);
    if (periph.timer_f_16bit_mode) begin
      set_per[IRF_PER_TFH] =
        ({periph.timer_f_count_high, periph.timer_f_count_low} ==
         {periph.timer_f_compare_high, periph.timer_f_compare_low});
    end else begin
      set_per[IRF_PER_TFH] =
        (periph.timer_f_count_high == periph.timer_f_compare_high);
      set_per[IRF_PER_TFL] =
        (periph.timer_f_count_low == periph.timer_f_compare_low);
    end
    set_per[IRF_PER_TC] =
      ((prev_timer_c == IRF_CNT_MAX) &&
       (periph.timer_c_count == IRF_CNT_ZERO)) ||
      ((prev_timer_c == IRF_CNT_ZERO) &&
       (periph.timer_c_count == IRF_CNT_MAX));
    set_per[IRF_PER_EC] = periph.event_16bit_mode ?
      periph.event_count_high_ovf :
      (periph.event_count_high_ovf | periph.event_count_low_ovf);
  end

  // ************************************************************
  // avalon slave, one wait state on every access
  // ************************************************************
  always_comb begin
    wr_go = avs_write & acked;
    // capture on the first request cycle so data stands with waitrequest low
    rd_go = avs_read & ~acked;
    next_acked = (avs_read | avs_write) & ~acked;
    wmask = avs_byteenable[0] ? avs_writedata[7:0] : 8'hff;
  end

  // ************************************************************
  // flag and control next state
  // ************************************************************
  always_comb begin
    next_tsp = timer_serial_pin_request_flags;
    next_per = peripheral_request_flags;
    next_wkp = wakeup_request_flags;
    next_pes = pin_edge_select;
    next_wes = wakeup_edge_select;
    next_prev_interval = periph.interval_count;
    next_prev_timer_c = periph.timer_c_count;
    next_prev_converter_start_flag = periph.converter_start_flag;
    if (wr_go) begin
      unique case (avs_address)
        IRF_OFS_TSP: next_tsp = next_tsp & wmask;
        IRF_OFS_PER: begin
          next_per = next_per & wmask;
          if (avs_byteenable[0]) begin
            next_per[IRF_PER_RSV] = avs_writedata[IRF_PER_RSV];
          end
        end
        IRF_OFS_WKP: next_wkp = next_wkp & wmask;
        IRF_OFS_CTL: begin
          if (avs_byteenable[0]) begin
            next_pes = avs_writedata[IRF_CTL_PES_LSB +: PINS];
          end
          if (avs_byteenable[1]) begin
            next_wes = avs_writedata[IRF_CTL_WES_LSB +: WAKES];
          end
        end
        default: ;
      endcase
    end
    // set wins over a simultaneous clear; nothing clears on acceptance
    next_tsp = next_tsp | set_tsp;
    next_per = next_per | set_per;
    next_wkp = next_wkp | 8'(wake_hit);
    next_tsp[IRF_TSP_FIX] = 1'b1;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_go) begin
      unique case (avs_address)
        IRF_OFS_TSP: next_rdata[7:0] = timer_serial_pin_request_flags;
        IRF_OFS_PER: next_rdata[7:0] = peripheral_request_flags;
        IRF_OFS_WKP: next_rdata[7:0] = wakeup_request_flags;
        IRF_OFS_CTL: begin
          next_rdata[IRF_CTL_PES_LSB +: PINS] = pin_edge_select;
          next_rdata[IRF_CTL_WES_LSB +: WAKES] = wakeup_edge_select;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_serial_pin_request_flags <= IRF_RST_FLAGS;
      peripheral_request_flags <= IRF_RST_FLAGS;
      wakeup_request_flags <= IRF_RST_FLAGS;
      pin_edge_select <= IRF_RST_PES[PINS-1:0];
      wakeup_edge_select <= IRF_RST_WES[WAKES-1:0];
      prev_interval <= IRF_CNT_ZERO;
      prev_timer_c <= IRF_CNT_ZERO;
      prev_converter_start_flag <= 1'b0;
      acked <= 1'b0;
      rdata <= 32'h0000_0000;
      timer_serial_pin_flags <= IRF_RST_FLAGS;
      peripheral_flags <= IRF_RST_FLAGS;
      wakeup_flags <= IRF_RST_FLAGS;
    end else begin
      timer_serial_pin_request_flags <= next_tsp;
      peripheral_request_flags <= next_per;
      wakeup_request_flags <= next_wkp;
      pin_edge_select <= next_pes;
      wakeup_edge_select <= next_wes;
      prev_interval <= next_prev_interval;
      prev_timer_c <= next_prev_timer_c;
      prev_converter_start_flag <= next_prev_converter_start_flag;
      acked <= next_acked;
      rdata <= next_rdata;
      timer_serial_pin_flags <= next_tsp;
      peripheral_flags <= next_per;
      wakeup_flags <= next_wkp;
    end
  end

  always_comb begin
    avs_readdata = rdata;
  end

  // waitrequest is the registered inverse of the one-wait-state ack
  logic wait_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~next_acked;
    end
  end

  always_comb begin
    avs_waitrequest = wait_q;
  end
endmodule : irf_top
`default_nettype wire

/* test/irf_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module irf_properties
  import irf_pkg::*;
#(parameter int WAKES = 8)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire irf_periph_t periph,
  input wire logic [WAKES-1:0] wakeup_pin_enable,
  input wire logic [7:0] timer_serial_pin_flags,
  input wire logic [7:0] peripheral_flags,
  input wire logic [7:0] wakeup_flags
);
  // ****************
  // flag properties
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wr_ok;
  assign wr_ok = avs_write && !avs_waitrequest;
  sequence wr_per_s;
    wr_ok && avs_address == IRF_OFS_PER && avs_byteenable[0];
  endsequence
  fix_bit_a: assert property ($past(rst_n) |->
    timer_serial_pin_flags[IRF_TSP_FIX]) else $error("fixed bit low");
  rst_clear_a: assert property (!$past(rst_n) |->
    {peripheral_flags, wakeup_flags, timer_serial_pin_flags[7:6],
    timer_serial_pin_flags[4:0]} == 23'h0) else $error("reset left flags");
  ivl_set_a: assert property ($past(rst_n) &&
    $past(periph.interval_count) == IRF_CNT_MAX &&
    periph.interval_count == IRF_CNT_ZERO |-> ##[1:2]
    timer_serial_pin_flags[IRF_TSP_TA]) else $error("no interval flag");
  ser_set_a: assert property ($rose(timer_serial_pin_flags[IRF_TSP_S1])
    |-> $past(periph.serial_one_done)) else $error("serial flag uncaused");
  tc_set_a: assert property ($past(rst_n) &&
    (periph.timer_c_count ^ $past(periph.timer_c_count)) == 8'hff &&
    (periph.timer_c_count == IRF_CNT_MAX || periph.timer_c_count ==
    IRF_CNT_ZERO) |-> ##[1:2] peripheral_flags[IRF_PER_TC])
    else $error("no timer c flag");
  per_hold_a: assert property ($past(rst_n) &&
    (~peripheral_flags & $past(peripheral_flags)) != 8'h0 |->
    $past(wr_ok && avs_address == IRF_OFS_PER)) else $error("flag lost");
  wake_hold_a: assert property ($past(rst_n) &&
    (~wakeup_flags & $past(wakeup_flags)) != 8'h0 |->
    $past(wr_ok && avs_address == IRF_OFS_WKP)) else $error("wake lost");
  wake_set_a: assert property ((wakeup_flags & ~$past(wakeup_flags) &
    ~$past(wakeup_pin_enable)) == 8'h0) else $error("wake uncaused");
  rsv_bit_a: assert property (wr_per_s |=>
    peripheral_flags[IRF_PER_RSV] == $past(avs_writedata[IRF_PER_RSV]))
    else $error("reserved bit not stored");
endmodule : irf_properties
bind irf_top irf_properties #(.WAKES(WAKES)) props (
  .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .periph(periph), .wakeup_pin_enable(wakeup_pin_enable),
  .timer_serial_pin_flags(timer_serial_pin_flags),
  .peripheral_flags(peripheral_flags), .wakeup_flags(wakeup_flags));
`default_nettype wire

/* test/irf_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module irf_partner
  import irf_pkg::*;
(
  input wire logic mclk,
  output var irf_periph_t periph,
  output logic [4:0] ext_pin,
  output logic [7:0] wk_pin
);
  // ****************
  // peripheral events
  // ****************
  localparam irf_periph_t IDLE = '{interval_count: 8'h10,
    timer_c_count: 8'h10, timer_f_count_high: 8'h01,
    timer_f_count_low: 8'h01, default: '0};
  initial begin
    periph = IDLE;
    ext_pin = 5'h1f;
    wk_pin = 8'hff;
  end
  task automatic fire(input int k);
    irf_periph_t p;
    p = IDLE;
    case (k)
      0: p.interval_count = 8'hff;
      1: p.serial_one_done = 1'b1;
      2: {p.sleep_exec, p.direct_transfer_on} = 2'b11;
      3: p.sleep_exec = 1'b1;
      4: p.converter_start_flag = 1'b1;
      5: p.timer_g_capture_edge = 1'b1;
      6: {p.timer_g_overflow, p.overflow_irq_enable} = 2'b11;
      7: p.timer_g_overflow = 1'b1;
      8: p.timer_f_count_high = 8'h00;
      9: p.timer_f_count_low = 8'h00;
      10: {p.timer_f_16bit_mode, p.timer_f_count_high} = 9'h100;
      11: {p.timer_f_16bit_mode, p.timer_f_count_high,
        p.timer_f_count_low} = 17'h10000;
      12: p.timer_c_count = 8'hff;
      13: p.timer_c_count = 8'h00;
      14: p.event_count_high_ovf = 1'b1;
      15: p.event_count_low_ovf = 1'b1;
      16: {p.event_16bit_mode, p.event_count_low_ovf} = 2'b11;
      default: p = IDLE;
    endcase
    @(posedge mclk);
    periph <= p;
    p = IDLE;
    if (k == 0) p.interval_count = 8'h00;
    if (k == 12) p.timer_c_count = 8'h00;
    if (k == 13) p.timer_c_count = 8'hff;
    @(posedge mclk);
    periph <= p;
    @(posedge mclk);
    periph <= IDLE;
  endtask : fire
  task automatic pins(input logic [4:0] e, input logic [7:0] w);
    @(posedge mclk);
    ext_pin <= e;
    wk_pin <= w;
  endtask : pins
endmodule : irf_partner
`default_nettype wire

/* test/tb_interrupt_request_flags.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; $display("FAIL %0t got %h want %h", $time, a, e); end end
module tb_interrupt_request_flags
  import irf_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  irf_periph_t periph;
  logic [4:0] ext_pin;
  logic [4:0] ext_en = 5'h0f;
  logic [7:0] wk_pin;
  logic [7:0] wk_en = 8'h7f;
  logic [15:0] q;
  logic [7:0] tsp_o;
  logic [7:0] per_o;
  logic [7:0] wkp_o;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  localparam logic [7:0] EV_EXP [17] = '{8'ha0, 8'h60, 8'h80, 8'h00,
    8'h40, 8'h10, 8'h10, 8'h00, 8'h08, 8'h04, 8'h00, 8'h08, 8'h02,
    8'h02, 8'h01, 8'h01, 8'h00};
  always #20 mclk = ~mclk;
  irf_top dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .periph(periph), .external_request_pin(ext_pin),
    .external_pin_enable(ext_en), .wakeup_pin(wk_pin),
    .wakeup_pin_enable(wk_en), .timer_serial_pin_flags(tsp_o),
    .peripheral_flags(per_o), .wakeup_flags(wkp_o));
  irf_partner prt (.mclk(mclk), .periph(periph), .ext_pin(ext_pin),
    .wk_pin(wk_pin));
  // ****************
  // bus access
  // ****************
  task automatic bus(input logic [3:0] a, input logic w,
      input logic [15:0] d, input logic [3:0] be);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {16'h0, d};
    avs_byteenable <= be;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(a, 1'b1, d, 4'h3);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    bus(a, 1'b0, 16'h0, 4'hf);
    `CHK(q, e)
  endtask : rd
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(IRF_OFS_TSP, 16'h20);
    `CHK(tsp_o, 8'h20)
    rd(IRF_OFS_PER, 16'h0);
    rd(IRF_OFS_WKP, 16'h0);
    rd(IRF_OFS_CTL, 16'h0);
    rd(4'h2, 16'h0);
    wr(IRF_OFS_TSP, 16'hff);
    rd(IRF_OFS_TSP, 16'h20);
    wr(IRF_OFS_PER, 16'hff);
    rd(IRF_OFS_PER, 16'h20);
    wr(IRF_OFS_WKP, 16'hff);
    rd(IRF_OFS_WKP, 16'h0);
    for (int k = 0; k < 17; k++) begin
      wr(IRF_OFS_TSP, 16'h0);
      wr(IRF_OFS_PER, 16'h0);
      prt.fire(k);
      rd(k < 2 ? IRF_OFS_TSP : IRF_OFS_PER, {8'h0, EV_EXP[k]});
      rd(k < 2 ? IRF_OFS_TSP : IRF_OFS_PER, {8'h0, EV_EXP[k]});
      `CHK(k < 2 ? tsp_o : per_o, EV_EXP[k])
    end
    prt.pins(5'h00, 8'h00);
    rd(IRF_OFS_TSP, 16'h2f);
    rd(IRF_OFS_WKP, 16'h7f);
    wr(4'h2, 16'h0);
    bus(IRF_OFS_TSP, 1'b1, 16'h0, 4'h0);
    rd(IRF_OFS_TSP, 16'h2f);
    wr(IRF_OFS_TSP, 16'hfd);
    rd(IRF_OFS_TSP, 16'h2d);
    wr(IRF_OFS_WKP, 16'hfe);
    rd(IRF_OFS_WKP, 16'h7e);
    prt.pins(5'h1f, 8'hff);
    wr(IRF_OFS_TSP, 16'h0);
    wr(IRF_OFS_WKP, 16'h0);
    rd(IRF_OFS_TSP, 16'h20);
    rd(IRF_OFS_WKP, 16'h0);
    wr(IRF_OFS_CTL, 16'hff1f);
    rd(IRF_OFS_CTL, 16'hff1f);
    prt.pins(5'h00, 8'h00);
    rd(IRF_OFS_TSP, 16'h20);
    prt.pins(5'h1f, 8'hff);
    rd(IRF_OFS_TSP, 16'h2f);
    rd(IRF_OFS_WKP, 16'h7f);
    `CHK(wkp_o, 8'h7f)
    give_verdict;
  end
endmodule : tb_interrupt_request_flags
`default_nettype wire
